// ==== dv/injseq_top_props.sv ====
// Port-level assertions for the injector current sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "injseq_consts.vh"
module injseq_top_props
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic WR,
  input wire logic SHORT_HIGH,
  input wire logic SHORT_LOW,
  input wire logic [2:0] CHAN_SEL,
  input wire logic BOOST_DRIVE,
  input wire logic BATT_DRIVE,
  input wire logic ENERGY_RETURN,
  input wire logic CRIT_FAULT
);
  // =============================================================
  // Properties
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  sequence s_launch;
    !BOOST_DRIVE ##1 BOOST_DRIVE;
  endsequence
  sequence s_fault_held;
    CRIT_FAULT [*2];
  endsequence
  a_one_chan:
    assert property ($onehot0(CHAN_SEL)) else $error("channel overlap");
  a_launch_idle:
    assert property (s_launch |-> $past(CHAN_SEL) == 3'h0 && $onehot(CHAN_SEL))
      else $error("boost outside pulse start");
  a_boost_alone:
    assert property (BOOST_DRIVE |-> !BATT_DRIVE && !ENERGY_RETURN)
      else $error("boost overlaps other drive");
  a_return_quiet:
    assert property (ENERGY_RETURN |-> !BATT_DRIVE && CHAN_SEL != 3'h0)
      else $error("return with drive on");
  a_idle_quiet:
    assert property (CHAN_SEL == 3'h0 |-> !BOOST_DRIVE && !BATT_DRIVE)
      else $error("drive while idle");
  a_short_trip:
    assert property (SHORT_HIGH || SHORT_LOW |-> ##[1:2] CRIT_FAULT)
      else $error("short not flagged");
  a_fault_stop:
    assert property (s_fault_held |-> CHAN_SEL == 3'h0 && !BATT_DRIVE)
      else $error("drive after fault");
  a_fault_hold:
    assert property (CRIT_FAULT && !(WR && ADDR == `REG_STATUS) |=> CRIT_FAULT)
      else $error("fault cleared by itself");
endmodule
bind injseq_top injseq_top_props injseq_top_props_inst
(
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR(WR),
  .SHORT_HIGH(SHORT_HIGH), .SHORT_LOW(SHORT_LOW), .CHAN_SEL(CHAN_SEL),
  .BOOST_DRIVE(BOOST_DRIVE), .BATT_DRIVE(BATT_DRIVE),
  .ENERGY_RETURN(ENERGY_RETURN), .CRIT_FAULT(CRIT_FAULT)
);
`default_nettype wire

// ==== dv/injseq_top_tb_top.sv ====
// Self-checking testbench for the injector current sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "injseq_consts.vh"
module injseq_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq, crit;
  logic sh = 1'b0, sl = 1'b0, ds = 1'b0, openl = 1'b0, bst, bat, ret;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [2:0] cmd = 3'h0, sel, opn;
  logic [11:0] cur;
  wire [3:0] drv = {cur >= 12'h190, ret, bat, bst};
  int n_fail = 0, cmp_count = 0, k, n;
  always #10 clk = ~clk;
  injseq_top injseq_top_inst (.CLK_SYS(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .CMD(cmd),
    .CURRENT_MA_DIV8(cur), .SHORT_HIGH(sh), .SHORT_LOW(sl),
    .DRIVER_SHORT(ds), .CHAN_SEL(sel), .BOOST_DRIVE(bst), .BATT_DRIVE(bat),
    .ENERGY_RETURN(ret), .CRIT_FAULT(crit), .OPEN_LOAD(opn));
  solenoid_model solenoid_model_inst (.clk(clk), .rst(rst), .boost(bst),
    .batt(bat), .open_load(openl), .current(cur));
  // =============================================================
  // Access and checking tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts cycles while the chosen drv bit (a drive output or the current-at-peak flag) keeps the given level.
  task automatic span(input int w, input logic v, input int lim);
    n = 0;
    while (drv[w] === v && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic until_sel(input logic [2:0] e, input int lim);
    for (int i = 0; i <= lim; i++)
    begin
      @(posedge clk);
      #1 if (sel === e) return;
    end
    chk(sel, e);
    end_of_test;
  endtask
  initial
  begin
    #400000 n_fail++;
    end_of_test;
  end
  // =============================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wreg(4'hF, 32'hFFFFFFFF);
    rreg(4'hF);
    chk(d, 32'h0);
    wreg(`REG_BOOST_DUR, 32'h14);
    wreg(`REG_PEAK_DUR, 32'hBB8);
    wreg(`REG_ERET_DUR, 32'hA);
    // Targets sit above the open-load level so a good coil passes boost.
    wreg(`REG_PEAK_TGT, 32'h190);
    wreg(`REG_HOLD_TGT, 32'h12C);
    wreg(`REG_MASK, 32'h8);
    wreg(`REG_CTRL, 32'h1);
    cmd <= 3'b011;
    until_sel(3'b001, 4);
    chk(bst, 1'b1);
    span(0, 1'b1, 30);
    chk(n < 20, 1'b1);
    span(3, 1'b1, 200);
    span(1, 1'b0, 3000);
    chk(n >= 2499 && n <= 2504, 1'b1);
    rreg(`REG_PHASE);
    chk(d, 32'h2);
    repeat (500) @(posedge clk);
    rreg(`REG_PHASE);
    chk(d, 32'h3);
    cmd <= 3'b010;
    span(2, 1'b0, 5);
    span(2, 1'b1, 20);
    chk(n, 32'hA);
    until_sel(3'b010, 4);
    wreg(`REG_ERET_DUR, 32'h0);
    cmd <= 3'b000;
    span(2, 1'b0, 16);
    chk(n, 32'h10);
    chk(sel, 3'b000);
    openl <= 1'b1;
    cmd <= 3'b001;
    until_sel(3'b001, 4);
    until_sel(3'b000, 25);
    cmd <= 3'b000;
    chk({crit, irq, opn}, 5'h09);
    wreg(`REG_MASK, 32'h0);
    #1 chk(irq, 1'b0);
    wreg(`REG_MASK, 32'h8);
    openl <= 1'b0;
    cmd <= 3'b001;
    repeat (30) @(posedge clk);
    #1 chk({irq, opn}, 4'h0);
    cmd <= 3'b000;
    until_sel(3'b000, 4);
    for (k = 0; k < 3; k++)
    begin
      cmd <= 3'b001;
      until_sel(3'b001, 4);
      {sh, sl, ds} <= 3'b100 >> k;
      repeat (4) @(posedge clk);
      {sh, sl, ds} <= 3'b000;
      rreg(`REG_STATUS);
      chk(d[2:0], (k == 2) ? 3'b010 : 3'b001);
      chk(sel, 3'b000);
      wreg(`REG_STATUS, 32'h7);
      cmd <= 3'b000;
      #1 chk(crit, 1'b0);
    end
    end_of_test;
  end
endmodule
`default_nettype wire

// ==== dv/solenoid_model.sv ====
// Behavioural solenoid coil feeding the current sense input.
`timescale 1ns/10ps
`default_nettype none
module solenoid_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic boost,
  input wire logic batt,
  input wire logic open_load,
  output logic [11:0] current
);
  // An open coil or a grounded low terminal hides all current from sensing.
  always @(posedge clk or posedge rst)
    if (rst || open_load)
      current <= 12'h000;
    else if (boost)
      current <= current + 12'h028;
    else if (batt)
      current <= current + 12'h004;
    else if (current > 12'h002)
      current <= current - 12'h002;
    else
      current <= 12'h000;
endmodule
`default_nettype wire

// ==== pkg/injseq_consts.vh ====
// Constants for the solenoid injector current sequencer.
`ifndef INJSEQ_CONSTS_VH
`define INJSEQ_CONSTS_VH
// =============================================================
// Register offsets (word addresses on the plain register port)
`define REG_CTRL 4'h0
`define REG_BOOST_DUR 4'h1
`define REG_PEAK_DUR 4'h2
`define REG_ERET_DUR 4'h3
`define REG_PEAK_TGT 4'h4
`define REG_HOLD_TGT 4'h5
`define REG_STATUS 4'h6
`define REG_MASK 4'h7
`define REG_PHASE 4'h8
// =============================================================
// Field positions
`define CTRL_ENABLE 0
`define ST_SHORT 0
`define ST_BOOST_DRV 1
`define ST_BATT_DRV 2
`define ST_OPEN0 3
`define ST_PULSE_END 6
`define ST_WIDTH 7
// =============================================================
// Reset values
`define RST_BOOST_DUR 16'h0000
`define RST_PEAK_DUR 16'h0000
`define RST_ERET_DUR 16'h0000
`define RST_TGT 12'h000
// =============================================================
// Timing
`define CLK_MHZ 50
`define OPEN_LOAD_MA 2000
`define RESTART_US 50
`define RESTART_CYC (`RESTART_US * `CLK_MHZ)
`endif

// ==== rtl/injseq_top.v ====
// Three-channel solenoid injector current sequencer with fault handling.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "injseq_consts.vh"
// =============================================================
module injseq_top
(
  input wire CLK_SYS,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  output wire IRQ,
  input wire [2:0] CMD,
  input wire [11:0] CURRENT_MA_DIV8,
  input wire SHORT_HIGH,
  input wire SHORT_LOW,
  input wire DRIVER_SHORT,
  output reg [2:0] CHAN_SEL,
  output reg BOOST_DRIVE,
  output reg BATT_DRIVE,
  output reg ENERGY_RETURN,
  output wire CRIT_FAULT,
  output wire [2:0] OPEN_LOAD
);

  localparam S_IDLE = 3'd0;
  localparam S_BOOST = 3'd1;
  localparam S_BPEAK = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_RET = 3'd4;
  localparam [11:0] OPEN_TH = `OPEN_LOAD_MA / 8;
  localparam [11:0] RESTART_N = `RESTART_CYC;

  reg enable_r;
  reg [15:0] boost_dur_r;
  reg [15:0] peak_dur_r;
  reg [15:0] eret_dur_r;
  reg [11:0] peak_tgt_r;
  reg [11:0] hold_tgt_r;
  reg [`ST_WIDTH-1:0] status_r;
  reg [`ST_WIDTH-1:0] mask_r;
  reg [2:0] phase_r;
  reg [2:0] phase_nxt;
  reg [1:0] chan_r;
  reg [15:0] tmr_r;
  reg [11:0] wait_r;
  reg waiting_r;
  reg over_open_r;
  reg [`ST_WIDTH-1:0] ev;
  wire critical;
  wire [11:0] thresh;
  wire [2:0] req_mask;

  // Fixed priority pick among waiting commands.
  function [1:0] pick;
    input [2:0] r;
    begin
      if (r[0])
        pick = 2'd0;
      else if (r[1])
        pick = 2'd1;
      else
        pick = 2'd2;
    end
  endfunction

  assign critical = status_r[`ST_SHORT] | status_r[`ST_BOOST_DRV]
    | status_r[`ST_BATT_DRV];
  assign CRIT_FAULT = critical;
  assign OPEN_LOAD = status_r[`ST_OPEN0+2:`ST_OPEN0];
  assign IRQ = |(status_r & mask_r);
  assign thresh = (phase_r == S_HOLD) ? hold_tgt_r : peak_tgt_r;
  assign req_mask = CMD & {3{enable_r & ~critical}};

  // =============================================================
  // Phase sequencer
  always @*
  begin
    phase_nxt = phase_r;
    ev = {`ST_WIDTH{1'b0}};
    case (phase_r)
      S_IDLE:
        if (|req_mask)
          phase_nxt = S_BOOST;
      S_BOOST:
        if (tmr_r + 16'd1 >= boost_dur_r || CURRENT_MA_DIV8 >= peak_tgt_r)
        begin
          // Low terminal grounded looks the same as an open coil.
          if (!over_open_r && CURRENT_MA_DIV8 <= OPEN_TH)
          begin
            ev[`ST_OPEN0 + chan_r] = 1'b1;
            phase_nxt = (eret_dur_r == 16'h0000) ? S_IDLE : S_RET;
          end
          else
            phase_nxt = S_BPEAK;
        end
      S_BPEAK:
        if (!CMD[chan_r])
          phase_nxt = (eret_dur_r == 16'h0000) ? S_IDLE : S_RET;
        else if (tmr_r + 16'd1 >= peak_dur_r)
          phase_nxt = S_HOLD;
      S_HOLD:
        if (!CMD[chan_r])
          phase_nxt = (eret_dur_r == 16'h0000) ? S_IDLE : S_RET;
      S_RET:
        if (tmr_r + 16'd1 >= eret_dur_r)
          phase_nxt = S_IDLE;
      default:
        phase_nxt = S_IDLE;
    endcase
    if (SHORT_HIGH | SHORT_LOW)
      ev[`ST_SHORT] = 1'b1;
    if (DRIVER_SHORT && phase_r == S_BOOST)
      ev[`ST_BOOST_DRV] = 1'b1;
    if (DRIVER_SHORT && (phase_r == S_BPEAK || phase_r == S_HOLD))
      ev[`ST_BATT_DRV] = 1'b1;
    if (phase_r != S_IDLE && phase_nxt == S_IDLE)
      ev[`ST_PULSE_END] = 1'b1;
    if (critical || ev[2:0] != 3'b000)
      phase_nxt = S_IDLE;
  end

  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      phase_r <= S_IDLE;
      chan_r <= 2'd0;
      tmr_r <= 16'h0000;
      wait_r <= 12'h000;
      waiting_r <= 1'b0;
      over_open_r <= 1'b0;
      CHAN_SEL <= 3'b000;
      BOOST_DRIVE <= 1'b0;
      BATT_DRIVE <= 1'b0;
      ENERGY_RETURN <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      if (phase_nxt != phase_r)
        tmr_r <= (phase_nxt == S_BPEAK) ? tmr_r + 16'd1 : 16'h0000;
      else
        tmr_r <= tmr_r + 16'd1;
      if (phase_r == S_IDLE && phase_nxt == S_BOOST)
        chan_r <= pick(req_mask);
      if (phase_r == S_IDLE)
        over_open_r <= 1'b0;
      else if (CURRENT_MA_DIV8 > OPEN_TH)
        over_open_r <= 1'b1;
      // Battery drive: off at threshold, back on 50 us after falling below.
      if (phase_nxt == S_BPEAK || phase_nxt == S_HOLD)
      begin
        if (CURRENT_MA_DIV8 >= thresh)
        begin
          BATT_DRIVE <= 1'b0;
          waiting_r <= 1'b0;
        end
        else if (!BATT_DRIVE && !waiting_r)
        begin
          waiting_r <= 1'b1;
          wait_r <= 12'h000;
        end
        else if (waiting_r)
        begin
          wait_r <= wait_r + 12'd1;
          if (wait_r + 12'd1 >= RESTART_N)
          begin
            BATT_DRIVE <= 1'b1;
            waiting_r <= 1'b0;
          end
        end
      end
      else
      begin
        BATT_DRIVE <= 1'b0;
        waiting_r <= 1'b0;
      end
      BOOST_DRIVE <= (phase_nxt == S_BOOST);
      ENERGY_RETURN <= (phase_nxt == S_RET);
      if (phase_nxt == S_IDLE)
        CHAN_SEL <= 3'b000;
      else if (phase_r == S_IDLE)
        CHAN_SEL <= 3'b001 << pick(req_mask);
    end
  end

  // =============================================================
  // Register port
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      enable_r <= 1'b0;
      boost_dur_r <= `RST_BOOST_DUR;
      peak_dur_r <= `RST_PEAK_DUR;
      eret_dur_r <= `RST_ERET_DUR;
      peak_tgt_r <= `RST_TGT;
      hold_tgt_r <= `RST_TGT;
      mask_r <= {`ST_WIDTH{1'b0}};
      status_r <= {`ST_WIDTH{1'b0}};
      RDATA <= 32'h00000000;
    end
    else
    begin
      if (WR)
      begin
        if (ADDR == `REG_CTRL)
          enable_r <= WDATA[`CTRL_ENABLE];
        else if (ADDR == `REG_BOOST_DUR)
          boost_dur_r <= WDATA[15:0];
        else if (ADDR == `REG_PEAK_DUR)
          peak_dur_r <= WDATA[15:0];
        else if (ADDR == `REG_ERET_DUR)
          eret_dur_r <= WDATA[15:0];
        else if (ADDR == `REG_PEAK_TGT)
          peak_tgt_r <= WDATA[11:0];
        else if (ADDR == `REG_HOLD_TGT)
          hold_tgt_r <= WDATA[11:0];
        else if (ADDR == `REG_MASK)
          mask_r <= WDATA[`ST_WIDTH-1:0];
      end
      // Write one clears; a same-cycle event wins over the clear.
      status_r <= (status_r & ~((WR && ADDR == `REG_STATUS) ?
        WDATA[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}})) | ev;
      // A clean pass through boost clears that channel's open flag.
      if (phase_r == S_BOOST && phase_nxt == S_BPEAK)
        status_r[`ST_OPEN0 + chan_r] <= 1'b0;
      RDATA <= 32'h00000000;
      if (RD)
      begin
        if (ADDR == `REG_CTRL)
          RDATA <= {31'h00000000, enable_r};
        else if (ADDR == `REG_BOOST_DUR)
          RDATA <= {16'h0000, boost_dur_r};
        else if (ADDR == `REG_PEAK_DUR)
          RDATA <= {16'h0000, peak_dur_r};
        else if (ADDR == `REG_ERET_DUR)
          RDATA <= {16'h0000, eret_dur_r};
        else if (ADDR == `REG_PEAK_TGT)
          RDATA <= {20'h00000, peak_tgt_r};
        else if (ADDR == `REG_HOLD_TGT)
          RDATA <= {20'h00000, hold_tgt_r};
        else if (ADDR == `REG_STATUS)
          RDATA <= {25'h0000000, status_r};
        else if (ADDR == `REG_MASK)
          RDATA <= {25'h0000000, mask_r};
        else if (ADDR == `REG_PHASE)
          RDATA <= {27'h0000000, chan_r, phase_r};
      end
    end
  end

endmodule
`default_nettype wire
